// >>> design/sma_arbiter.sv
`timescale 1ns/1ps
`include "sma_consts.svh"
module sma_arbiter
    import sma_pkg::*;
(
    input  wire logic        MCLK,
    input  wire logic        RST,
    input  wire logic        HOST_CARD_ADDRESSED_N,
    input  wire logic        HOST_LOWER_STROBE_N,
    input  wire logic        HOST_READ_NOT_WRITE,
    input  wire logic [14:0] HOST_ADDR,
    input  wire logic [7:0]  HOST_WDATA,
    output logic      [7:0]  HOST_RDATA,
    output logic             HOST_DTACK_N,
    output logic             HOST_IRQ_N,
    input  wire logic        LOCAL_MEM_REQUEST_N,
    input  wire logic        LOCAL_REFRESH_N,
    input  wire logic        LOCAL_RD_N,
    input  wire logic        LOCAL_ADDR_TOP_BIT,
    input  wire logic [14:0] LOCAL_ADDR,
    input  wire logic [7:0]  LOCAL_CPU_BUS_IN,
    output logic      [7:0]  LOCAL_CPU_BUS_OUT,
    output logic             LOCAL_CPU_BUS_OE_N,
    output logic             LOCAL_WAIT_N,
    output logic      [14:0] SHARED_ADDR,
    output logic      [7:0]  SHARED_BUS_N_OUT,
    output logic             SHARED_BUS_N_OE_N,
    input  wire logic [7:0]  SHARED_BUS_N_IN,
    output logic             SHARED_SELECT_N,
    output logic             SHARED_READ_STROBE_N,
    output logic             SHARED_WRITE_STROBE_N,
    output logic             RAM1_SELECT_N,
    output logic             RAM2_SELECT_N,
    input  wire logic [3:0]  STATUS_NIBBLE_R0,
    input  wire logic [3:0]  STATUS_NIBBLE_R1,
    input  wire logic [7:0]  MODEM_STATUS,
    output logic      [7:0]  MODEM_CONTROL,
    output logic             CARD_RESET,
    output logic             HOST_IRQ_ENABLE_N,
    output logic             SERIAL_CTL_B_INPUT_N
);

    // ************************************************************
    // input synchronisers
    // ************************************************************

    logic [2:0] lds_s_q;          // host lower strobe, three stages
    logic [2:0] myp_s_q;          // host card match, three stages
    logic [2:0] mrq_s_q;          // local memory request, three stages
    logic [2:0] rfs_s_q;          // local refresh, three stages
    logic       lds_q;            // filtered host strobe (low active)
    logic       myp_q;            // filtered card match (low active)
    logic       mrq_q;            // filtered local mem request
    logic       rfs_q;            // filtered local refresh

    // three flops, change accepted when stages two and three agree
    always_ff @(posedge MCLK)
    begin
        if (RST)
        begin
            lds_s_q <= 3'h7;
            myp_s_q <= 3'h7;
            mrq_s_q <= 3'h7;
            rfs_s_q <= 3'h7;
            lds_q   <= 1'b1;
            myp_q   <= 1'b1;
            mrq_q   <= 1'b1;
            rfs_q   <= 1'b1;
        end
        else
        begin
            lds_s_q <= {lds_s_q[1:0], HOST_LOWER_STROBE_N};
            myp_s_q <= {myp_s_q[1:0], HOST_CARD_ADDRESSED_N};
            mrq_s_q <= {mrq_s_q[1:0], LOCAL_MEM_REQUEST_N};
            rfs_s_q <= {rfs_s_q[1:0], LOCAL_REFRESH_N};
            if (lds_s_q[1] == lds_s_q[2])
                lds_q <= lds_s_q[2];
            if (myp_s_q[1] == myp_s_q[2])
                myp_q <= myp_s_q[2];
            if (mrq_s_q[1] == mrq_s_q[2])
                mrq_q <= mrq_s_q[2];
            if (rfs_s_q[1] == rfs_s_q[2])
                rfs_q <= rfs_s_q[2];
        end
    end

    // ************************************************************
    // half-rate phase
    // ************************************************************

    logic [1:0] phase_q;          // four fast edges per half-rate period

    // phase counter: 0 = half rise, 1 = fast fall slot, 2 = half fall
    always_ff @(posedge MCLK)
    begin
        if (RST)
            phase_q <= 2'h0;
        else
            phase_q <= phase_q + 2'h1;
    end

    logic half_rise;              // enable standing for half-rate rising edge
    logic half_fall;              // enable standing for half-rate falling edge
    logic sel_tick;               // alternate fast falling edge

    assign half_rise = (phase_q == 2'h0);
    assign half_fall = (phase_q == 2'h2);
    assign sel_tick  = (phase_q == 2'h1);

    // ************************************************************
    // requests and selection
    // ************************************************************

    sma_state_t state_q;          // timing chain
    sma_owner_t owner_q;          // access select flip-flop
    logic       cyc_en_q;         // host cycle enable flag
    logic       host_req;         // host shared request
    logic       loc_req;          // local shared request
    logic       sel_req;          // request of the selected owner
    logic       active;           // shared cycle in progress

    assign active   = (state_q != SMA_IDLE);
    assign host_req = !lds_q && !myp_q && cyc_en_q;
    assign loc_req  = !mrq_q && LOCAL_ADDR_TOP_BIT && rfs_q;
    assign sel_req  = (owner_q == SMA_OWN_HOST) ? host_req : loc_req;

    // access select: frozen during a cycle, local by default
    always_ff @(posedge MCLK)
    begin
        if (RST)
            owner_q <= SMA_OWN_LOCAL;
        else if (sel_tick && !active)
            owner_q <= host_req ? SMA_OWN_HOST : SMA_OWN_LOCAL;
    end

    logic [14:0] addr_q;          // shared address latch
    logic        rnw_q;           // latched direction, high = read
    logic [7:0]  wdata_q;         // latched write data

    // address and direction latch, clock frozen in a cycle
    always_ff @(posedge MCLK)
    begin
        if (RST)
        begin
            addr_q  <= 15'h0000;
            rnw_q   <= 1'b1;
            wdata_q <= 8'h00;
        end
        else if (half_fall && !active)
        begin
            addr_q  <= (owner_q == SMA_OWN_HOST) ? HOST_ADDR : LOCAL_ADDR;
            rnw_q   <= (owner_q == SMA_OWN_HOST) ? HOST_READ_NOT_WRITE : !LOCAL_RD_N ? 1'b1 : 1'b0;
            wdata_q <= (owner_q == SMA_OWN_HOST) ? HOST_WDATA : LOCAL_CPU_BUS_IN;
        end
    end

    // ************************************************************
    // timing chain
    // ************************************************************

    // stage one starts, stage two follows, idle after withdrawal
    always_ff @(posedge MCLK)
    begin
        if (RST)
            state_q <= SMA_IDLE;
        else if (half_rise)
        begin
            case (state_q)
                SMA_IDLE:
                    if (sel_req)
                        state_q <= SMA_STAGE1;
                SMA_STAGE1:
                    state_q <= sel_req ? SMA_STAGE2 : SMA_IDLE;
                SMA_STAGE2:
                    if (!sel_req)
                        state_q <= SMA_IDLE;
                default:
                    state_q <= SMA_IDLE;
            endcase
        end
    end

    // cycle enable cleared once the host lets go inside its own cycle, re-armed when the chain idles;
    // clearing at cycle start would drop the host request and end the cycle before acknowledge
    always_ff @(posedge MCLK)
    begin
        if (RST)
            cyc_en_q <= 1'b1;
        else if (half_rise && active && !sel_req && owner_q == SMA_OWN_HOST)
            cyc_en_q <= 1'b1;
        else if (active && lds_q && owner_q == SMA_OWN_HOST)
            cyc_en_q <= 1'b0;
    end

    logic xcv_en;                 // owner transceiver enabled
    logic host_own;               // host owns the cycle
    logic wr_cyc;                 // write cycle in progress

    assign host_own = (owner_q == SMA_OWN_HOST);
    assign xcv_en   = active && sel_req;
    assign wr_cyc   = active && !rnw_q;

    // strobes and handshakes
    assign SHARED_SELECT_N       = !active;
    assign SHARED_READ_STROBE_N  = !(active && rnw_q);
    assign SHARED_WRITE_STROBE_N = !(wr_cyc && state_q == SMA_STAGE1);
    assign HOST_DTACK_N          = !(host_own && state_q == SMA_STAGE2);
    assign LOCAL_WAIT_N          = !(loc_req && !(active && !host_own));
    assign SHARED_ADDR           = addr_q;

    // ************************************************************
    // decode
    // ************************************************************

    logic [1:0] blk;              // {a14,a13}
    logic       reg_sel;          // hardware registers selected
    logic       ram1_sel;         // ram block one selected

    assign blk      = addr_q[14:13];
    assign reg_sel  = active && (addr_q[14:2] == 13'h0000);
    assign ram1_sel = active && (blk == `SMA_BLK_RAM1);
    assign RAM1_SELECT_N = !ram1_sel;
    assign RAM2_SELECT_N = !(active && blk == `SMA_BLK_RAM2);

    logic rd_pulse;               // one cycle as the first stage of a read ends
    logic wr_pulse;               // one cycle as the first stage of a write ends
    logic rd_end;                 // trailing edge of a read

    assign rd_pulse = half_rise && state_q == SMA_STAGE1 && rnw_q;
    assign wr_pulse = half_rise && state_q == SMA_STAGE1 && !rnw_q;
    assign rd_end   = half_rise && active && !sel_req && rnw_q;

    // ************************************************************
    // hardware registers
    // ************************************************************

    logic       card_rst_q;       // card reset flip-flop
    logic       irq_en_n_q;       // interrupt enable, low = enabled
    logic       irq_n_q;          // interrupt request, low = requesting
    logic       cmd_q;            // command flag
    logic       sema_q;           // semaphore, 0 = busy
    logic [7:0] modem_q;          // modem control latch

    // register writes, card reset side effects
    always_ff @(posedge MCLK)
    begin
        if (RST)
        begin
            card_rst_q <= 1'b1;
            irq_en_n_q <= 1'b1;
            modem_q    <= `SMA_RST_MODEM;
        end
        else
        begin
            if (wr_pulse && reg_sel && addr_q[1:0] == `SMA_REG_RESET)
                card_rst_q <= wdata_q[`SMA_BIT_CTRL];
            if (card_rst_q)
            begin
                irq_en_n_q <= 1'b1;
                modem_q    <= `SMA_RST_MODEM;
            end
            else
            begin
                if (wr_pulse && reg_sel && addr_q[1:0] == `SMA_REG_IRQEN)
                    irq_en_n_q <= wdata_q[`SMA_BIT_CTRL];
                if (wr_pulse && reg_sel && addr_q[1:0] == `SMA_REG_MODEM)
                    modem_q <= wdata_q;
            end
        end
    end

    // semaphore: read end sets (wins), write clears, reset busy
    always_ff @(posedge MCLK)
    begin
        if (RST || card_rst_q)
            sema_q <= 1'b0;
        else if (rd_end && reg_sel && addr_q[1:0] == `SMA_REG_SEMA)
            sema_q <= 1'b1;
        else if (wr_pulse && reg_sel && addr_q[1:0] == `SMA_REG_SEMA)
            sema_q <= 1'b0;
    end

    // interrupt request and command flags in ram block one
    always_ff @(posedge MCLK)
    begin
        if (RST || card_rst_q)
        begin
            irq_n_q <= 1'b1;
            cmd_q   <= 1'b1;
        end
        else if (ram1_sel && addr_q[12:0] == `SMA_LOC_CAUSE)
        begin
            if (wr_pulse && !host_own)
                irq_n_q <= 1'b0;
            else if (rd_pulse && host_own)
                irq_n_q <= 1'b1;
        end
        else if (ram1_sel && addr_q[12:0] == `SMA_LOC_CMD && wr_pulse)
            cmd_q <= !host_own;
    end

    // ************************************************************
    // data paths
    // ************************************************************

    logic [7:0] rd_val;           // register read value, true polarity

    // register read mux
    always_comb
    begin
        rd_val = 8'h00;
        if (addr_q[1:0] == `SMA_REG_RESET || addr_q[1:0] == `SMA_REG_IRQEN)
        begin
            rd_val[7:4] = addr_q[0] ? STATUS_NIBBLE_R1 : STATUS_NIBBLE_R0;
            rd_val[`SMA_BIT_ID] = (addr_q[1:0] == `SMA_REG_RESET);
        end
        else if (addr_q[1:0] == `SMA_REG_MODEM)
            rd_val = MODEM_STATUS;
        else
            rd_val[`SMA_BIT_CTRL] = sema_q;
    end

    logic [7:0] rdata_q;          // captured read data, true polarity

    // capture read data while the owner's transceiver is enabled
    always_ff @(posedge MCLK)
    begin
        if (RST)
            rdata_q <= 8'h00;
        else if (xcv_en && rnw_q)
            rdata_q <= reg_sel ? rd_val : ~SHARED_BUS_N_IN;
    end

    assign SHARED_BUS_N_OUT   = ~wdata_q;
    assign SHARED_BUS_N_OE_N  = !(xcv_en && !rnw_q && !reg_sel);
    assign HOST_RDATA         = rdata_q;
    assign LOCAL_CPU_BUS_OUT  = rdata_q;
    assign LOCAL_CPU_BUS_OE_N = !(xcv_en && !host_own && rnw_q);
    assign MODEM_CONTROL      = modem_q;
    assign CARD_RESET         = card_rst_q;
    assign HOST_IRQ_ENABLE_N  = irq_en_n_q;
    assign HOST_IRQ_N         = irq_n_q | irq_en_n_q;
    assign SERIAL_CTL_B_INPUT_N = cmd_q;

endmodule

// >>> design/sma_consts.svh
// Overview of operation
// - sample host request on alternate fast falling edges
// - local processor owns bus by default
// - latch owner address and direction each half fall outside a cycle
// - first stage starts cycle, strobes, transceiver, wait
// - second stage ends write, acknowledges host
// - cycle held until owner withdraws request
// - first stage idles, clears second, re-arms host cycle enable
// - late requester stalled by wait or no acknowledge
// - second stage ignored on local reads
// - address bits 13 and 14 pick block
// - registers need bits 2 to 14 zero
// - write registers 0 and 1 keep bit 7
// - read registers 0,1 upper nibble muxed, bit 2
// - shared data bus is active low
// - register 2 modem control latch and status
// - register 3 test-and-set semaphore, write clears
// - first two ram locations drive interrupt flags
// - local request needs local_mem_request_n, top bit, no refresh
// - host request gated by cycle enable flag
// - card write sets, host read clears irq
// - card reset disables irq, semaphore busy
`ifndef SMA_CONSTS_SVH
`define SMA_CONSTS_SVH
// register select in address bits 1:0
`define SMA_REG_RESET    2'h0
`define SMA_REG_IRQEN    2'h1
`define SMA_REG_MODEM    2'h2
`define SMA_REG_SEMA     2'h3
// field positions
`define SMA_BIT_CTRL     7
`define SMA_BIT_ID       2
// block select codes {a14,a13}
`define SMA_BLK_REGS     2'h0
`define SMA_BLK_RAM1     2'h2
`define SMA_BLK_RAM2     2'h1
// interrupt locations in ram block one
`define SMA_LOC_CAUSE    13'h0000
`define SMA_LOC_CMD      13'h0001
// reset values
`define SMA_RST_MODEM    8'h00
`endif

// >>> design/sma_pkg.sv
package sma_pkg;
    // owner of the shared bus
    typedef enum logic {SMA_OWN_LOCAL, SMA_OWN_HOST} sma_owner_t;
    // timing chain state
    typedef enum logic [1:0] {SMA_IDLE, SMA_STAGE1, SMA_STAGE2} sma_state_t;
endpackage

// >>> verification/sma_asserts.sv
`timescale 1ns/1ps
// ****************************************
// arbiter port checker
// ****************************************
module sma_asserts
(
    input wire logic        MCLK,
    input wire logic        RST,
    input wire logic        HOST_LOWER_STROBE_N,
    input wire logic        HOST_DTACK_N,
    input wire logic        HOST_IRQ_N,
    input wire logic        HOST_IRQ_ENABLE_N,
    input wire logic        CARD_RESET,
    input wire logic        LOCAL_MEM_REQUEST_N,
    input wire logic        LOCAL_REFRESH_N,
    input wire logic        LOCAL_ADDR_TOP_BIT,
    input wire logic        LOCAL_WAIT_N,
    input wire logic [14:0] SHARED_ADDR,
    input wire logic        SHARED_SELECT_N,
    input wire logic        SHARED_WRITE_STROBE_N,
    input wire logic        RAM1_SELECT_N,
    input wire logic        RAM2_SELECT_N
);
    default clocking dc @(posedge MCLK); endclocking
    default disable iff (RST);
    // write strobe covers the first stage only
    sequence write_pulse;
        !SHARED_WRITE_STROBE_N [*4] ##1 SHARED_WRITE_STROBE_N;
    endsequence
    ack_timing_a: assert property (
        $fell(HOST_DTACK_N) |-> $past(SHARED_SELECT_N, 5) && !$past(SHARED_SELECT_N, 4)) else $error("ack timing");
    write_len_a: assert property (
        $fell(SHARED_SELECT_N) && !SHARED_WRITE_STROBE_N |-> write_pulse) else $error("write strobe length");
    strobe_in_cycle_a: assert property (
        !HOST_DTACK_N || !SHARED_WRITE_STROBE_N |-> !SHARED_SELECT_N) else $error("strobe outside cycle");
    cycle_hold_a: assert property (
        !HOST_DTACK_N && !HOST_LOWER_STROBE_N |=> !SHARED_SELECT_N) else $error("cycle dropped early");
    cycle_end_a: assert property (
        $rose(HOST_LOWER_STROBE_N) && !HOST_DTACK_N |-> ##[1:12] SHARED_SELECT_N) else $error("cycle not ended");
    idle_gap_a: assert property (
        $rose(SHARED_SELECT_N) |-> SHARED_SELECT_N [*4]) else $error("cycle off half rate edge");
    addr_frozen_a: assert property (
        !SHARED_SELECT_N && !$fell(SHARED_SELECT_N) |-> $stable(SHARED_ADDR)) else $error("address moved");
    block_decode_a: assert property (
        !SHARED_SELECT_N && $past(!SHARED_SELECT_N) |-> RAM1_SELECT_N == (SHARED_ADDR[14:13] != 2'h2)
        && RAM2_SELECT_N == (SHARED_ADDR[14:13] != 2'h1)) else $error("block decode");
    local_stall_a: assert property (
        !HOST_DTACK_N && !LOCAL_MEM_REQUEST_N && !$past(LOCAL_MEM_REQUEST_N, 4) && LOCAL_ADDR_TOP_BIT
        && LOCAL_REFRESH_N |-> !LOCAL_WAIT_N) else $error("local not stalled");
    reset_state_a: assert property (
        $fell(RST) |-> CARD_RESET && HOST_IRQ_N && HOST_IRQ_ENABLE_N) else $error("reset state");
    irq_gate_a: assert property (
        !HOST_IRQ_N |-> !HOST_IRQ_ENABLE_N) else $error("irq while disabled");
endmodule
bind sma_arbiter sma_asserts chk (.MCLK, .RST, .HOST_LOWER_STROBE_N, .HOST_DTACK_N, .HOST_IRQ_N,
    .HOST_IRQ_ENABLE_N, .CARD_RESET, .LOCAL_MEM_REQUEST_N, .LOCAL_REFRESH_N, .LOCAL_ADDR_TOP_BIT,
    .LOCAL_WAIT_N, .SHARED_ADDR, .SHARED_SELECT_N, .SHARED_WRITE_STROBE_N, .RAM1_SELECT_N, .RAM2_SELECT_N);

// >>> verification/sma_ram_model.sv
`timescale 1ns/1ps
// ****************************************
// shared ram on the inverted data bus
// ****************************************
module sma_ram_model
(
    input  wire logic        MCLK,
    input  wire logic        SLOW,
    input  wire logic [14:0] SHARED_ADDR,
    input  wire logic [7:0]  SHARED_BUS_N_OUT,
    input  wire logic        SHARED_READ_STROBE_N,
    input  wire logic        SHARED_WRITE_STROBE_N,
    input  wire logic        RAM1_SELECT_N,
    input  wire logic        RAM2_SELECT_N,
    output logic      [7:0]  SHARED_BUS_N_IN
);
    logic [7:0] mem [0:255];     // true data by low address byte
    logic       hit;             // a ram block is selected
    logic       rd_q   = 1'b0;   // read already one clock old
    logic [7:0] last_q = 8'h00;  // last value on the bus
    assign hit = !RAM1_SELECT_N || !RAM2_SELECT_N;
    // store writes, age reads, remember the bus
    always_ff @(posedge MCLK)
    begin
        if (hit && !SHARED_WRITE_STROBE_N)
            mem[SHARED_ADDR[7:0]] <= ~SHARED_BUS_N_OUT;
        rd_q <= hit && !SHARED_READ_STROBE_N;
        last_q <= SHARED_BUS_N_IN;
    end
    // the first clock of a slow read or an idle bus shows a pattern that flips every clock
    always_comb
        if (hit && !SHARED_READ_STROBE_N && (!SLOW || rd_q))
            SHARED_BUS_N_IN = ~mem[SHARED_ADDR[7:0]];
        else
            SHARED_BUS_N_IN = ~last_q;
endmodule

// >>> verification/shared_memory_arbiter_test.sv
`timescale 1ns/1ps
`define CK(n, e, g) begin tests_run++; if ((g) !== (e)) begin err_count++; \
    $display("mismatch %s exp %0h got %0h", n, e, g); end end
module shared_memory_arbiter_test;
    logic MCLK = 1'b0, RST = 1'b1, SLOW = 1'b0, seen;
    logic HOST_CARD_ADDRESSED_N = 1'b1, HOST_LOWER_STROBE_N = 1'b1, HOST_READ_NOT_WRITE = 1'b1;
    logic LOCAL_MEM_REQUEST_N = 1'b1, LOCAL_REFRESH_N = 1'b1, LOCAL_RD_N = 1'b1, LOCAL_ADDR_TOP_BIT = 1'b0;
    logic [14:0] HOST_ADDR = 15'h0000, LOCAL_ADDR = 15'h0000, SHARED_ADDR;
    logic [7:0] HOST_WDATA = 8'h00, LOCAL_CPU_BUS_IN = 8'h00, MODEM_STATUS = 8'h5A, rd, rd2;
    logic [7:0] HOST_RDATA, LOCAL_CPU_BUS_OUT, SHARED_BUS_N_OUT, SHARED_BUS_N_IN, MODEM_CONTROL;
    logic [3:0] STATUS_NIBBLE_R0 = 4'h9, STATUS_NIBBLE_R1 = 4'h6;
    logic HOST_DTACK_N, HOST_IRQ_N, LOCAL_CPU_BUS_OE_N, LOCAL_WAIT_N, SHARED_BUS_N_OE_N, SHARED_SELECT_N;
    logic SHARED_READ_STROBE_N, SHARED_WRITE_STROBE_N, RAM1_SELECT_N, RAM2_SELECT_N, CARD_RESET;
    logic HOST_IRQ_ENABLE_N, SERIAL_CTL_B_INPUT_N;
    int   err_count = 0, tests_run = 0, i;
    always #2 MCLK = ~MCLK;
    sma_arbiter dut (.MCLK, .RST, .HOST_CARD_ADDRESSED_N, .HOST_LOWER_STROBE_N, .HOST_READ_NOT_WRITE,
        .HOST_ADDR, .HOST_WDATA, .HOST_RDATA, .HOST_DTACK_N, .HOST_IRQ_N, .LOCAL_MEM_REQUEST_N,
        .LOCAL_REFRESH_N, .LOCAL_RD_N, .LOCAL_ADDR_TOP_BIT, .LOCAL_ADDR, .LOCAL_CPU_BUS_IN,
        .LOCAL_CPU_BUS_OUT, .LOCAL_CPU_BUS_OE_N, .LOCAL_WAIT_N, .SHARED_ADDR, .SHARED_BUS_N_OUT,
        .SHARED_BUS_N_OE_N, .SHARED_BUS_N_IN, .SHARED_SELECT_N, .SHARED_READ_STROBE_N,
        .SHARED_WRITE_STROBE_N, .RAM1_SELECT_N, .RAM2_SELECT_N, .STATUS_NIBBLE_R0, .STATUS_NIBBLE_R1,
        .MODEM_STATUS, .MODEM_CONTROL, .CARD_RESET, .HOST_IRQ_ENABLE_N, .SERIAL_CTL_B_INPUT_N);
    sma_ram_model part (.MCLK, .SLOW, .SHARED_ADDR, .SHARED_BUS_N_OUT, .SHARED_READ_STROBE_N,
        .SHARED_WRITE_STROBE_N, .RAM1_SELECT_N, .RAM2_SELECT_N, .SHARED_BUS_N_IN);
    // ****************************************
    // bus tasks
    // ****************************************
    task give_verdict;
        $display("errors %0d checks %0d", err_count, tests_run);
        if (err_count == 0 && tests_run > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask
    // a spent wait limit ends the run
    task check_to(input logic bad);
        if (bad)
        begin
            err_count++;
            $display("mismatch wait exp done got limit");
            give_verdict;
        end
    endtask
    task automatic wait_idle;
        int n;
        for (n = 0; n < 64 && SHARED_SELECT_N !== 1'b1; n++)
            @(negedge MCLK);
        check_to(n == 64);
    endtask
    // host: hold strobe until acknowledge, then release
    task automatic h_acc(input logic rnw, input logic [14:0] a, input logic [7:0] wd, output logic [7:0] r);
        int n;
        HOST_READ_NOT_WRITE = rnw;
        HOST_ADDR = a;
        HOST_WDATA = wd;
        HOST_CARD_ADDRESSED_N = 1'b0;
        HOST_LOWER_STROBE_N = 1'b0;
        for (n = 0; n < 64 && HOST_DTACK_N !== 1'b0; n++)
            @(negedge MCLK);
        check_to(n == 64);
        `CK("soe", rnw || a[14:2] == 13'h0000, SHARED_BUS_N_OE_N)
        r = HOST_RDATA;
        HOST_LOWER_STROBE_N = 1'b1;
        HOST_CARD_ADDRESSED_N = 1'b1;
        wait_idle;
    endtask
    // local: request, wait for grant, finish once in stage two
    task automatic l_acc(input logic rdn, input logic [14:0] a, input logic [7:0] wd, output logic [7:0] r);
        int n;
        LOCAL_RD_N = rdn;
        LOCAL_ADDR = a;
        LOCAL_CPU_BUS_IN = wd;
        LOCAL_ADDR_TOP_BIT = 1'b1;
        LOCAL_MEM_REQUEST_N = 1'b0;
        repeat (4) @(negedge MCLK);
        for (n = 0; n < 64 && (LOCAL_WAIT_N !== 1'b1 || SHARED_SELECT_N !== 1'b0); n++)
            @(negedge MCLK);
        check_to(n == 64);
        repeat (5) @(negedge MCLK);
        `CK("loe", rdn, LOCAL_CPU_BUS_OE_N)
        r = LOCAL_CPU_BUS_OUT;
        LOCAL_MEM_REQUEST_N = 1'b1;
        wait_idle;
    endtask
    // ****************************************
    // scenarios
    // ****************************************
    initial
    begin
        repeat (3) @(negedge MCLK);
        RST = 1'b0;
        @(negedge MCLK);
        `CK("crst", 1'b1, CARD_RESET)
        `CK("ien", 1'b1, HOST_IRQ_ENABLE_N)
        h_acc(1'b0, 15'h0000, 8'h7F, rd);
        `CK("crst", 1'b0, CARD_RESET)
        h_acc(1'b0, 15'h0001, 8'h7F, rd);
        `CK("ien", 1'b0, HOST_IRQ_ENABLE_N)
        h_acc(1'b0, 15'h0005, 8'hFF, rd);
        `CK("noreg", 1'b0, HOST_IRQ_ENABLE_N)
        h_acc(1'b1, 15'h0000, 8'h00, rd);
        `CK("reg0", {STATUS_NIBBLE_R0, 4'h4}, rd)
        l_acc(1'b0, 15'h0001, 8'h00, rd);
        `CK("reg1", {STATUS_NIBBLE_R1, 4'h0}, rd)
        h_acc(1'b0, 15'h0002, 8'hA5, rd);
        `CK("mctl", 8'hA5, MODEM_CONTROL)
        h_acc(1'b1, 15'h0002, 8'h00, rd);
        `CK("msts", MODEM_STATUS, rd)
        h_acc(1'b1, 15'h0003, 8'h00, rd);
        `CK("sem", 1'b0, rd[7])
        l_acc(1'b0, 15'h0003, 8'h00, rd);
        `CK("semset", 1'b1, rd[7])
        h_acc(1'b0, 15'h0003, 8'h00, rd);
        h_acc(1'b1, 15'h0003, 8'h00, rd);
        `CK("semclr", 1'b0, rd[7])
        h_acc(1'b0, 15'h2010, 8'h3C, rd);
        `CK("cell", 8'h3C, part.mem[8'h10])
        h_acc(1'b0, 15'h6010, 8'h77, rd);
        `CK("unused", 8'h3C, part.mem[8'h10])
        SLOW = 1'b1;
        l_acc(1'b0, 15'h2010, 8'h00, rd);
        `CK("lread", 8'h3C, rd)
        l_acc(1'b1, 15'h4000, 8'h01, rd);
        `CK("irqset", 1'b0, HOST_IRQ_N)
        h_acc(1'b1, 15'h4000, 8'h00, rd);
        `CK("cause", 8'h01, rd)
        `CK("irqclr", 1'b1, HOST_IRQ_N)
        h_acc(1'b0, 15'h4001, 8'h00, rd);
        `CK("cmdh", 1'b0, SERIAL_CTL_B_INPUT_N)
        l_acc(1'b1, 15'h4001, 8'h00, rd);
        `CK("cmdl", 1'b1, SERIAL_CTL_B_INPUT_N)
        fork
            h_acc(1'b0, 15'h2020, 8'hC3, rd);
            l_acc(1'b1, 15'h2021, 8'h5A, rd2);
        join
        `CK("hcell", 8'hC3, part.mem[8'h20])
        `CK("lcell", 8'h5A, part.mem[8'h21])
        // refresh, then low half: request ignored
        for (i = 0; i < 2; i++)
        begin
            LOCAL_REFRESH_N = i[0];
            LOCAL_ADDR_TOP_BIT = !i[0];
            LOCAL_MEM_REQUEST_N = 1'b0;
            seen = 1'b0;
            repeat (16)
            begin
                @(negedge MCLK);
                seen |= !SHARED_SELECT_N;
            end
            `CK("ignored", 1'b0, seen)
            LOCAL_MEM_REQUEST_N = 1'b1;
            LOCAL_REFRESH_N = 1'b1;
            repeat (8) @(negedge MCLK);
        end
        l_acc(1'b1, 15'h4000, 8'h02, rd);
        h_acc(1'b1, 15'h0003, 8'h00, rd);
        h_acc(1'b0, 15'h0000, 8'h80, rd);
        `CK("crst", 1'b1, CARD_RESET)
        `CK("ienoff", 1'b1, HOST_IRQ_ENABLE_N)
        `CK("irqoff", 1'b1, HOST_IRQ_N)
        h_acc(1'b1, 15'h0003, 8'h00, rd);
        `CK("sembusy", 1'b0, rd[7])
        give_verdict;
    end
endmodule
